/* dv/sfr_core_model.sv */
`timescale 1ns/100ps
// Core side of the register bus: writes and reads
module sfr_core_model
    import wide_timer_pkg::*;
(
    input wire logic clk_in,
    input wire logic [7:0] rdata_in,
    output sfr_req_t req_out,
    output logic [7:0] rd_addr_out
);
    // Idle bus at time zero
    initial begin
        req_out = '0;
        rd_addr_out = 8'h00;
    end
    // One-cycle write pulse; released fields show inverted junk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        req_out = {1'b1, a, d};
        @(negedge clk_in);
        req_out = {1'b0, ~a, ~d};
    endtask : wr
    // Address held across one edge, data taken once settled
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_in);
        rd_addr_out = a;
        @(negedge clk_in);
        d = rdata_in;
    endtask : rd
endmodule : sfr_core_model

/* dv/split_wide_capture_timer_bench.sv */
`timescale 1ns/100ps
module split_wide_capture_timer_bench;
    import wide_timer_pkg::*;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0; // Low through the first cycles
    logic cap_low_in = 1'b0;
    logic cap_high_in = 1'b0;
    logic ce_in = 1'b1; // Dropped once to prove the freeze
    logic irq_out;
    logic [7:0] rdata_out;
    logic [7:0] rd_addr_in;
    logic [7:0] v; // Last byte read
    sfr_req_t req_in;
    int bad_count = 0;
    int checks_done = 0;
    // Rows: address, byte written, byte read back; timer stays idle
    logic [23:0] rows [6] = '{24'hcc5a5a, 24'hcda5a5, 24'hca1212,
        24'hcb3434, 24'hb93030, 24'hc0ff00};
    // Free-running clock
    initial forever #5 clk_in = ~clk_in;
    split_wide_capture_timer u_dut (.clk_in(clk_in), .nrst_in(nrst_in),
        .ce_in(ce_in), .req_in(req_in), .rd_addr_in(rd_addr_in),
        .cap_low_in(cap_low_in), .cap_high_in(cap_high_in),
        .rdata_out(rdata_out), .irq_out(irq_out));
    sfr_core_model u_core (.clk_in(clk_in), .rdata_in(rdata_out),
        .req_out(req_in), .rd_addr_out(rd_addr_in));
    // Verdict and end of run
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    // Byte compare, four-state exact
    task automatic chk(input string n, input logic [7:0] e,
        input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // Read one register and compare
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        u_core.rd(a, v);
        chk($sformatf("reg %h", a), e, v);
    endtask : rdc
    // One-cycle capture trigger on either input
    task automatic pulse(input bit hi);
        @(negedge clk_in);
        if (hi) cap_high_in = 1'b1;
        else cap_low_in = 1'b1;
        @(negedge clk_in);
        cap_high_in = 1'b0;
        cap_low_in = 1'b0;
    endtask : pulse
    // Bounded wait for a control flag; a hang ends the run
    task automatic poll(input int b);
        for (int i = 0; i < 40; i++) begin
            u_core.rd(ADDR_CONTROL, v);
            if (v[b] === 1'b1) return;
        end
        bad_count++;
        $display("mismatch flag %0d expected 1 seen 0", b);
        close_out();
    endtask : poll
    // Main sequence
    initial begin
        repeat (4) @(negedge clk_in);
        nrst_in = 1'b1;
        foreach (rows[i]) begin
            u_core.wr(rows[i][23:16], rows[i][15:8]);
            rdc(rows[i][23:16], rows[i][7:0]);
        end
        // Wide run by high enable, two counts from the top
        u_core.wr(ADDR_COUNT_LOW, 8'hfe);
        u_core.wr(ADDR_COUNT_HIGH, 8'hff);
        u_core.wr(ADDR_CONTROL, 8'h02);
        poll(BIT_HIGH_FLAG);
        chk("ctl", 8'hc2, v);
        @(negedge clk_in);
        chk("irq", 8'h01, {7'h0, irq_out});
        rdc(ADDR_COUNT_HIGH, 8'h34);
        u_core.wr(ADDR_CONTROL, 8'h00);
        rdc(ADDR_CONTROL, 8'h00);
        chk("irq", 8'h00, {7'h0, irq_out});
        // Split low half alone, interrupt masked then unmasked
        u_core.wr(ADDR_COUNT_LOW, 8'hfe);
        u_core.wr(ADDR_CONTROL, 8'h11);
        poll(BIT_LOW_FLAG);
        chk("ctl", 8'h51, v);
        @(negedge clk_in);
        chk("irq", 8'h00, {7'h0, irq_out});
        u_core.wr(ADDR_CONTROL, 8'h71);
        rdc(ADDR_CONTROL, 8'h71);
        chk("irq", 8'h01, {7'h0, irq_out});
        // Split capture on each half
        u_core.wr(ADDR_CONTROL, 8'h00);
        u_core.wr(ADDR_COUNT_LOW, 8'h5a);
        u_core.wr(ADDR_COUNT_HIGH, 8'ha5);
        u_core.wr(ADDR_CONTROL, 8'h1c);
        pulse(1'b0);
        rdc(ADDR_RELOAD_LOW, 8'h5a);
        rdc(ADDR_CONTROL, 8'h5c);
        pulse(1'b1);
        rdc(ADDR_RELOAD_HIGH, 8'ha5);
        rdc(ADDR_CONTROL, 8'hdc);
        // Wide capture: high trigger ignored, low copies both bytes
        u_core.wr(ADDR_CONTROL, 8'h00);
        u_core.wr(ADDR_RELOAD_LOW, 8'h00);
        u_core.wr(ADDR_RELOAD_HIGH, 8'h00);
        u_core.wr(ADDR_CONTROL, 8'h04);
        pulse(1'b1);
        rdc(ADDR_CONTROL, 8'h04);
        pulse(1'b0);
        rdc(ADDR_RELOAD_LOW, 8'h5a);
        rdc(ADDR_RELOAD_HIGH, 8'ha5);
        rdc(ADDR_CONTROL, 8'h84);
        chk("irq", 8'h01, {7'h0, irq_out});
        // Mid-run reset returns every register to zero
        @(negedge clk_in);
        nrst_in = 1'b0;
        @(negedge clk_in);
        nrst_in = 1'b1;
        for (int i = 0; i < 5; i++) rdc(rows[i][23:16], 8'h00);
        chk("irq", 8'h00, {7'h0, irq_out});
        // Wide run by the low enable alone
        u_core.wr(ADDR_COUNT_LOW, 8'hfe);
        u_core.wr(ADDR_COUNT_HIGH, 8'hff);
        u_core.wr(ADDR_CONTROL, 8'h01);
        poll(BIT_HIGH_FLAG);
        chk("ctl", 8'hc1, v);
        // Split high half alone, reload from its own byte
        u_core.wr(ADDR_CONTROL, 8'h00);
        u_core.wr(ADDR_RELOAD_HIGH, 8'h40);
        u_core.wr(ADDR_COUNT_HIGH, 8'hfe);
        u_core.wr(ADDR_CONTROL, 8'h12);
        poll(BIT_HIGH_FLAG);
        chk("ctl", 8'h92, v);
        rdc(ADDR_RELOAD_HIGH, 8'h40);
        u_core.wr(ADDR_CONTROL, 8'h00);
        // Clock enable low: a write must not land
        ce_in = 1'b0;
        u_core.wr(ADDR_RELOAD_LOW, 8'h77);
        ce_in = 1'b1;
        rdc(ADDR_RELOAD_LOW, 8'h00);
        close_out();
    end
endmodule : split_wide_capture_timer_bench

/* rtl/byte_counter.sv */
`timescale 1ns/100ps
// One 8-bit half: count, wrap flag, load port
module byte_counter (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    input wire logic inc_in,
    input wire logic load_in,
    input wire logic [7:0] load_val_in,
    output logic [7:0] count_out,
    output logic wrap_out
);
    // Wrap is combinational: all ones while incrementing
    assign wrap_out = inc_in && (count_out == 8'hff);

    // Load wins over increment
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            count_out <= 8'h00;
        end else if (ce_in) begin
            if (load_in) begin
                count_out <= load_val_in;
            end else if (inc_in) begin
                count_out <= count_out + 8'h01;
            end
        end
    end
endmodule : byte_counter

/* rtl/split_wide_capture_timer.sv */
`timescale 1ns/100ps
module split_wide_capture_timer
    import wide_timer_pkg::*;
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    input wire sfr_req_t req_in,
    input wire logic [7:0] rd_addr_in,
    input wire logic cap_low_in,
    input wire logic cap_high_in,
    output logic [7:0] rdata_out,
    output logic irq_out
);
    logic [7:0] ctrl_q;          // Control register
    logic [7:0] ctrl_d;
    logic [7:0] reload_low_q;    // Reload/capture low
    logic [7:0] reload_low_d;
    logic [7:0] reload_high_q;   // Reload/capture high
    logic [7:0] reload_high_d;
    logic [7:0] count_low;       // Live count bytes
    logic [7:0] count_high;
    logic [7:0] rdata_d;
    logic irq_d;

    // Control field decode
    // split select bit
    wire logic split = ctrl_q[BIT_SPLIT];
    wire logic low_cap = ctrl_q[BIT_LOW_CAP];
    wire logic high_cap = split & ctrl_q[BIT_HIGH_CAP];
    wire logic wide_run = ctrl_q[BIT_HIGH_RUN] | ctrl_q[BIT_LOW_RUN];
    wire logic low_run = split ? ctrl_q[BIT_LOW_RUN] : wide_run;
    wire logic low_wrap;
    wire logic high_wrap;
    // high carries from low in wide
    wire logic high_inc = split ? ctrl_q[BIT_HIGH_RUN] : low_wrap;

    // Bus write strobes
    wire logic wr_ctrl = req_in.wr && req_in.addr == ADDR_CONTROL;
    wire logic wr_rl = req_in.wr && req_in.addr == ADDR_RELOAD_LOW;
    wire logic wr_rh = req_in.wr && req_in.addr == ADDR_RELOAD_HIGH;
    wire logic wr_cl = req_in.wr && req_in.addr == ADDR_COUNT_LOW;
    wire logic wr_ch = req_in.wr && req_in.addr == ADDR_COUNT_HIGH;

    // wide capture uses low trigger and bit 2
    wire logic cap_lo_ev = low_cap & cap_low_in;
    wire logic cap_hi_ev = split ? (high_cap & cap_high_in) : cap_lo_ev;
    // Overflow events per half
    wire logic low_ovf = low_wrap;
    wire logic high_ovf = high_wrap;

    // reload on overflow in timer mode
    wire logic rl_low = split ? (low_ovf & ~low_cap)
                              : (high_ovf & ~low_cap);
    wire logic rl_high = split ? (high_ovf & ~high_cap)
                               : (high_ovf & ~low_cap);

    wire logic hi_flag_ev = (high_ovf & ~(~split & low_cap)) | cap_hi_ev;
    // low overflow sets low flag even in wide timer mode
    // wide capture sets low flag on high overflow
    wire logic lo_flag_ev = split ? (low_ovf | cap_lo_ev)
                          : (low_cap ? high_ovf : low_ovf);

    byte_counter u_low (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .ce_in(ce_in),
        .inc_in(low_run),
        .load_in(wr_cl | rl_low),
        .load_val_in(wr_cl ? req_in.wdata : reload_low_q),
        .count_out(count_low),
        .wrap_out(low_wrap)
    );

    byte_counter u_high (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .ce_in(ce_in),
        .inc_in(high_inc),
        .load_in(wr_ch | rl_high),
        .load_val_in(wr_ch ? req_in.wdata : reload_high_q),
        .count_out(count_high),
        .wrap_out(high_wrap)
    );

    // Control next value; hardware set wins over software clear
    always_comb begin
        ctrl_d = wr_ctrl ? req_in.wdata : ctrl_q;
        if (hi_flag_ev) begin
            ctrl_d[BIT_HIGH_FLAG] = 1'b1;
        end
        if (lo_flag_ev) begin
            ctrl_d[BIT_LOW_FLAG] = 1'b1;
        end
    end

    // Reload/capture bytes; capture beats software write
    always_comb begin
        reload_low_d = wr_rl ? req_in.wdata : reload_low_q;
        reload_high_d = wr_rh ? req_in.wdata : reload_high_q;
        if (cap_lo_ev) begin
            reload_low_d = count_low;
        end
        if (cap_hi_ev) begin
            reload_high_d = count_high;
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        case (rd_addr_in)
            ADDR_CONTROL: rdata_d = ctrl_d;
            ADDR_RELOAD_LOW: rdata_d = reload_low_q;
            ADDR_RELOAD_HIGH: rdata_d = reload_high_q;
            ADDR_COUNT_LOW: rdata_d = count_low;
            ADDR_COUNT_HIGH: rdata_d = count_high;
            default: rdata_d = 8'h00;
        endcase
    end

    assign irq_d = ctrl_d[BIT_HIGH_FLAG]
                 | (ctrl_d[BIT_LOW_FLAG] & ctrl_d[BIT_LOW_IRQ_EN]);

    // Registers; clock enable freezes all
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            ctrl_q <= CONTROL_RESET;
            reload_low_q <= BYTE_RESET;
            reload_high_q <= BYTE_RESET;
            rdata_out <= BYTE_RESET;
            irq_out <= 1'b0;
        end else if (ce_in) begin
            ctrl_q <= ctrl_d;
            reload_low_q <= reload_low_d;
            reload_high_q <= reload_high_d;
            rdata_out <= rdata_d;
            irq_out <= irq_d;
        end
    end

    // Irq matches the registered flags in the same cycle after each enabled edge
    AST_IRQ: assert property (@(posedge clk_in) disable iff (!nrst_in)
        ce_in |=> irq_out == (ctrl_q[7] | (ctrl_q[6] & ctrl_q[5])))
        else $error("irq mismatch");
    // High flag sticky against hardware
    AST_HFLAG: assert property (@(posedge clk_in) disable iff (!nrst_in)
        ctrl_q[7] && !wr_ctrl |=> ctrl_q[7])
        else $error("high flag cleared");
    AST_LFLAG: assert property (@(posedge clk_in) disable iff (!nrst_in)
        ce_in && lo_flag_ev |=> ctrl_q[6])
        else $error("low flag not set");
    AST_LOWOVF: assert property (@(posedge clk_in) disable iff (!nrst_in)
        ce_in && !low_cap && low_run && count_low == 8'hff |=> ctrl_q[6])
        else $error("low overflow lost");
    AST_WIDECAP: assert property (@(posedge clk_in) disable iff (!nrst_in)
        ce_in && !split && low_cap && cap_low_in |=> ctrl_q[7])
        else $error("wide capture flag");
    AST_CAPCOPY: assert property (@(posedge clk_in) disable iff (!nrst_in)
        ce_in && cap_lo_ev |=> reload_low_q == $past(count_low))
        else $error("capture copy wrong");
    AST_RELOAD: assert property (@(posedge clk_in) disable iff (!nrst_in)
        ce_in && split && !low_cap && !wr_cl && low_run
        && count_low == 8'hff |=> count_low == $past(reload_low_q))
        else $error("reload wrong");
    AST_WR: assert property (@(posedge clk_in) disable iff (!nrst_in)
        ce_in && wr_rh && !cap_hi_ev |=> reload_high_q == $past(req_in.wdata))
        else $error("reload write lost");
    AST_HCAPIGN: assert property (@(posedge clk_in) disable iff (!nrst_in)
        ce_in && !split && !low_cap && cap_high_in && !wr_rh
        |=> $stable(reload_high_q))
        else $error("high capture not ignored");
    // High capture copies the high live byte
    AST_CAPHI: assert property (@(posedge clk_in) disable iff (!nrst_in)
        ce_in && cap_hi_ev |=> reload_high_q == $past(count_high))
        else $error("high capture copy wrong");
    // Wide: high byte moves only on a low carry or a bus write to it
    AST_CARRY: assert property (@(posedge clk_in) disable iff (!nrst_in)
        ce_in && !split && count_low != 8'hff && !wr_ch
        |=> $stable(count_high))
        else $error("high byte moved without carry");
    // Wide with both run bits low: whole count frozen
    AST_WIDEIDLE: assert property (@(posedge clk_in) disable iff (!nrst_in)
        ce_in && !split && !ctrl_q[BIT_HIGH_RUN] && !ctrl_q[BIT_LOW_RUN]
        && !wr_cl && !wr_ch |=> $stable({count_high, count_low}))
        else $error("wide timer counted while stopped");
    // Split: high half idle without its own run bit
    AST_HIIDLE: assert property (@(posedge clk_in) disable iff (!nrst_in)
        ce_in && split && !ctrl_q[BIT_HIGH_RUN] && !wr_ch
        |=> $stable(count_high))
        else $error("high half counted while stopped");
    // Split: low half idle without its own run bit
    AST_LOIDLE: assert property (@(posedge clk_in) disable iff (!nrst_in)
        ce_in && split && !ctrl_q[BIT_LOW_RUN] && !wr_cl
        |=> $stable(count_low))
        else $error("low half counted while stopped");
endmodule : split_wide_capture_timer

/* rtl/wide_timer_pkg.sv */
package wide_timer_pkg;
    // Register addresses on the special-function-register bus
    localparam logic [7:0] ADDR_CONTROL = 8'hb9;
    localparam logic [7:0] ADDR_RELOAD_LOW = 8'hca;
    localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hcb;
    localparam logic [7:0] ADDR_COUNT_LOW = 8'hcc;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'hcd;
    // Reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    // Control bit positions
    localparam int BIT_HIGH_FLAG = 7;
    localparam int BIT_LOW_FLAG = 6;
    localparam int BIT_LOW_IRQ_EN = 5;
    localparam int BIT_SPLIT = 4;
    localparam int BIT_HIGH_CAP = 3;
    localparam int BIT_LOW_CAP = 2;
    localparam int BIT_HIGH_RUN = 1;
    localparam int BIT_LOW_RUN = 0;
    // Register bus request
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_t;
endpackage : wide_timer_pkg
